/* File: design/usmr_pkg.sv */
// Package with constants and carrier types for the serial port SPI-master / RS-485 block.
package usmr_pkg;
   // Line-driver mode field width and encodings.
   localparam int unsigned LDM_W = 2;
   localparam logic [1:0] LDM_OFF = 2'h0;
   localparam logic [1:0] LDM_EXT = 2'h1;
   localparam logic [1:0] LDM_INT = 2'h2;
   // Operating mode field: asynchronous framing or master SPI.
   localparam logic MODE_ASYNC = 1'h0;
   localparam logic MODE_SPI = 1'h1;
   // Data width of one character.
   localparam int unsigned DATA_W = 8;
   localparam logic [3:0] BIT_LAST = 4'h7;
   // Baud divisor width; divisor N gives one baud tick every N+1 clocks.
   localparam int unsigned DIV_W = 16;
   localparam logic [15:0] DIV_RST = 16'h0000;
   // Reset value of the data byte.
   localparam logic [7:0] DATA_RST = 8'h00;

   // Static configuration travelling as one group.
   typedef struct packed {
      logic mode;
      logic clock_phase_select;
      logic clock_polarity;
      logic bit_order_select;
      logic two_stop;
      logic [1:0] line_driver_mode;
      logic [15:0] divisor;
   } usmr_cfg_t;

   // Pin outputs travelling as one group.
   typedef struct packed {
      logic txd;
      logic txd_oe;
      logic transfer_clock_line;
      logic transmit_enable_out;
   } usmr_pins_t;
endpackage : usmr_pkg

/* File: design/usmr_core.sv */
// Serial port transmit path with master SPI shifting and RS-485 transmit-enable control.
//
// Functional notes
// RQ1: Clock phase selects sample and shift edge.
// RQ2: Bit order selects MSB or LSB first.
// RQ3: No write-collision flag in SPI master.
// RQ4: No double speed; divisor sets rate.
// RQ5: Interrupt timing differs from standalone SPI.
// RQ6: TxD out, RxD in, transfer clock driven.
// RQ7: No slave select; other logic drives it.
// RQ8: Mode 0x1 drives external driver enable.
// RQ9: Mode 0x2 releases TxD when idle.
// RQ10: Transmit enable high while transmitter active.
// RQ11: Enable rises one baud tick before data.
// RQ12: Enable held through last stop bit.
// RQ13: Enable low after frame, off when disabled.
`timescale 1ns/1ps
`default_nettype none

module usmr_core (
   input wire logic i_ref_clk,                  // 100 MHz peripheral clock.
   input wire logic i_rst_n,                    // Synchronous reset, active low.
   input wire usmr_pkg::usmr_cfg_t i_cfg,       // Static configuration.
   input wire logic [7:0] i_tx_data,            // Byte to send.
   input wire logic i_tx_valid,                 // Byte offered.
   output logic o_tx_ready,                     // Byte accepted this cycle.
   input wire logic i_rxd,                      // Receive pin, asynchronous.
   output logic [7:0] o_rx_data,                // Last byte received in SPI mode.
   output logic o_rx_valid,                     // One-cycle pulse when a byte lands.
   output logic o_busy,                         // Transmitter active.
   output usmr_pkg::usmr_pins_t o_pins          // Pin outputs.
);

   ////////////////////////////////////////////////////////////////////////////
   // Types and helpers.

   // Transmit sequencer states.
   typedef enum logic [2:0] {USMR_IDLE, USMR_GUARD, USMR_START, USMR_DATA,
                             USMR_STOP} usmr_state_t;

   // Picks the bit for position idx in the chosen order.
   function automatic logic usmr_pick(input logic [7:0] b, input logic [3:0] idx,
                                      input logic lsb_first);
      logic [2:0] p;
      p = idx[2:0];
      if (lsb_first) begin
         usmr_pick = b[p];
      end else begin
         usmr_pick = b[3'h7 - p];
      end
   endfunction : usmr_pick

   usmr_state_t state;            // Sequencer state.
   logic [15:0] div_cnt;          // Baud divider counter.
   logic tick;                    // One baud tick (half bit period in SPI mode).
   logic [7:0] shreg;             // Transmit byte held for the frame.
   logic [7:0] rxsh;              // Receive shift register.
   logic [3:0] bit_idx;           // Current data bit index.
   logic half;                    // SPI half-bit phase: 0 leading edge next, 1 trailing.
   logic stop_cnt;                // Second stop bit pending.
   logic rxd_s1;                  // Synchroniser first stage.
   logic rxd_s2;                  // Synchroniser second stage.
   logic sck;                     // Transfer clock level before polarity.
   logic txd;                     // Transmit data level.
   logic line_driver_mode_on;                // Line-driver mode 0x1 or 0x2 selected.
   logic take;                    // A byte is accepted now.
   logic spi;                     // Master SPI mode.

   assign spi = (i_cfg.mode == usmr_pkg::MODE_SPI);
   assign line_driver_mode_on = (i_cfg.line_driver_mode == usmr_pkg::LDM_EXT) ||
                     (i_cfg.line_driver_mode == usmr_pkg::LDM_INT); // RQ8
   // A new byte is only taken while idle, so a write during a frame simply waits;
   // there is no collision detection at all.
   assign take = i_tx_valid && (state == USMR_IDLE); // RQ3
   assign o_tx_ready = take;
   assign o_busy = (state != USMR_IDLE); // RQ10

   ////////////////////////////////////////////////////////////////////////////
   // Receive pin synchroniser.

   // The first stage is read only by the second.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         rxd_s1 <= 1'h1;
         rxd_s2 <= 1'h1;
      end else begin
         rxd_s1 <= i_rxd;
         rxd_s2 <= rxd_s1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Baud divider.

   // Rate comes only from the divisor; there is no double-speed shortcut.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n || state == USMR_IDLE) begin
         div_cnt <= usmr_pkg::DIV_RST;
      end else if (div_cnt >= i_cfg.divisor) begin // RQ4
         div_cnt <= usmr_pkg::DIV_RST;
      end else begin
         div_cnt <= div_cnt + 16'h0001;
      end
   end
   assign tick = (state != USMR_IDLE) && (div_cnt >= i_cfg.divisor);

   ////////////////////////////////////////////////////////////////////////////
   // Frame sequencer.

   // Asynchronous frames: with RS-485 on, a guard tick precedes the start bit.
   // SPI frames go straight to data; each bit spans two ticks.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         state <= USMR_IDLE;
         bit_idx <= 4'h0;
         half <= 1'h0;
         stop_cnt <= 1'h0;
      end else begin
         case (state)
            USMR_IDLE: begin
               if (take) begin
                  bit_idx <= 4'h0;
                  half <= 1'h0;
                  stop_cnt <= i_cfg.two_stop;
                  if (spi) begin
                     state <= USMR_DATA;
                  end else if (line_driver_mode_on) begin
                     state <= USMR_GUARD; // RQ11
                  end else begin
                     state <= USMR_START;
                  end
               end
            end
            USMR_GUARD: begin
               if (tick) begin
                  state <= USMR_START;
               end
            end
            USMR_START: begin
               if (tick) begin
                  state <= USMR_DATA;
               end
            end
            USMR_DATA: begin
               if (tick) begin
                  if (spi && !half) begin
                     half <= 1'h1;
                  end else begin
                     half <= 1'h0;
                     if (bit_idx == usmr_pkg::BIT_LAST) begin
                        state <= spi ? USMR_IDLE : USMR_STOP;
                     end else begin
                        bit_idx <= bit_idx + 4'h1;
                     end
                  end
               end
            end
            USMR_STOP: begin
               if (tick) begin
                  if (stop_cnt) begin
                     stop_cnt <= 1'h0; // RQ12
                  end else begin
                     state <= USMR_IDLE; // RQ13
                  end
               end
            end
            default: begin
               state <= USMR_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Data hold and receive capture.

   // Holds the byte; in SPI mode the receive bit is sampled on the sampling edge.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         shreg <= usmr_pkg::DATA_RST;
         rxsh <= usmr_pkg::DATA_RST;
      end else if (take) begin
         shreg <= i_tx_data;
      end else if (spi && state == USMR_DATA && tick && (half == i_cfg.clock_phase_select)) begin
         // Phase 0 samples at the leading edge, phase 1 at the trailing edge.
         if (i_cfg.bit_order_select) begin // RQ2
            rxsh <= {rxd_s2, rxsh[7:1]}; // RQ6
         end else begin
            rxsh <= {rxsh[6:0], rxd_s2}; // RQ1
         end
      end
   end

   // Publishes the received byte at the end of each SPI frame.
   // The pulse point is our own and need not match the standalone SPI unit.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         o_rx_data <= usmr_pkg::DATA_RST;
         o_rx_valid <= 1'h0;
      end else begin
         o_rx_valid <= 1'h0;
         if (spi && state == USMR_DATA && tick && half &&
             bit_idx == usmr_pkg::BIT_LAST) begin // RQ5
            o_rx_valid <= 1'h1;
            o_rx_data <= (i_cfg.clock_phase_select) ?
                         (i_cfg.bit_order_select ? {rxd_s2, rxsh[7:1]} : {rxsh[6:0], rxd_s2}) :
                         rxsh;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin drive.

   // Registered pin levels. With phase 1 the data changes at the leading edge,
   // with phase 0 it is set up half a bit earlier and changes at the trailing edge.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         txd <= 1'h1;
         sck <= 1'h0;
      end else begin
         case (state)
            USMR_START: txd <= 1'h0;
            USMR_DATA: begin
               if (spi) begin
                  // Transfer clock toggles once per tick.
                  sck <= tick ? ~half : sck; // RQ6
                  if (i_cfg.clock_phase_select && tick && !half) begin // RQ1
                     txd <= usmr_pick(shreg, bit_idx, i_cfg.bit_order_select);
                  end else if (!i_cfg.clock_phase_select && (!tick || half)) begin
                     txd <= usmr_pick(shreg, (tick && half) ? bit_idx + 4'h1 : bit_idx,
                                      i_cfg.bit_order_select); // RQ2
                  end
               end else begin
                  txd <= usmr_pick(shreg, bit_idx, i_cfg.bit_order_select); // RQ2
               end
            end
            default: begin
               txd <= 1'h1;
               sck <= 1'h0;
            end
         endcase
      end
   end

   // True while the sequencer is active, or when a queued byte is taken back to back
   // while the level is already up. Following the state one clock late keeps the level
   // in step with the registered data pin, so it covers the whole stop bit on the pin.
   function automatic logic next_active(input usmr_state_t s, input logic t,
                                        input logic cur);
      next_active = (s != USMR_IDLE) || (t && cur); // RQ12
   endfunction : next_active

   logic te_out;                  // Registered transmit enable level.
   logic txd_drive;               // Registered output enable of the transmit pin.

   // In async mode with line-driver mode 0x1 or 0x2, transmit enable is high through guard, start, data and stop, low otherwise.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         te_out <= 1'h0;
         txd_drive <= 1'h1;
      end else begin
         te_out <= line_driver_mode_on && !spi && next_active(state, take, te_out); // RQ10
         // In internal mode the pin is released while nothing is sent.
         txd_drive <= (i_cfg.line_driver_mode == usmr_pkg::LDM_INT) ?
                      next_active(state, take, txd_drive) : 1'h1; // RQ9
      end
   end

   // Pins; no slave select exists, the system drives one from a general output.
   assign o_pins = '{txd: txd, // RQ7
                     txd_oe: txd_drive,
                     transfer_clock_line: sck ^ i_cfg.clock_polarity, // RQ6
                     transmit_enable_out: te_out};

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   // Enable follows the active transmitter in RS-485 async mode.
   sequence usmr_frame_ends_s;
      (state == USMR_STOP) ##1 (state == USMR_IDLE);
   endsequence

   te_tracks_busy_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RQ10
      (line_driver_mode_on && !spi && $stable(i_cfg) && o_busy) |=>
      o_pins.transmit_enable_out)
      else $error("transmit enable does not track busy");

   guard_before_start_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RQ11
      (state == USMR_GUARD) |=> o_pins.transmit_enable_out && o_pins.txd)
      else $error("no guard tick before start bit");

   te_through_stop_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RQ12
      (line_driver_mode_on && !spi && state == USMR_STOP) |-> o_pins.transmit_enable_out)
      else $error("transmit enable dropped before stop end");

   te_low_after_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RQ13
      usmr_frame_ends_s ##0 !i_tx_valid |=> !o_pins.transmit_enable_out)
      else $error("transmit enable stays high after frame");

   te_off_disabled_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RQ8
      !$past(line_driver_mode_on) && !line_driver_mode_on |-> !o_pins.transmit_enable_out)
      else $error("transmit enable high while mode off");

   txd_release_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RQ9
      (i_cfg.line_driver_mode == usmr_pkg::LDM_INT) && $past(i_rst_n) &&
      ($past(i_cfg.line_driver_mode) == usmr_pkg::LDM_INT) && !o_busy && !$past(o_busy)
      |-> !o_pins.txd_oe)
      else $error("transmit pin not released when idle");

   no_take_busy_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RQ3
      o_busy |-> !o_tx_ready)
      else $error("byte accepted during a transfer");

   spi_clock_idle_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RQ6
      (state == USMR_IDLE) ##1 (state == USMR_IDLE) |->
      (o_pins.transfer_clock_line == i_cfg.clock_polarity))
      else $error("transfer clock not idle");

endmodule : usmr_core
`default_nettype wire

/* File: verification/usmr_spi_slave.sv */
// Behavioural SPI slave that faces the serial port in master SPI mode.
`timescale 1ns/1ps
`default_nettype none
module usmr_spi_slave (
   input wire logic i_sck,             // Transfer clock from the master.
   input wire logic i_mosi,            // Master data out.
   input wire logic i_cpol,            // Idle level of the clock.
   input wire logic i_cpha,            // Clock phase in use.
   input wire logic i_lsb_first,       // Bit order in use.
   input wire logic i_load,            // A rising edge arms a new byte.
   input wire logic [7:0] i_load_data, // Byte to return.
   output logic o_miso,                // Slave data out.
   output logic [7:0] o_got            // Byte captured from the master.
);
   logic [7:0] tx_byte = 8'h00;        // Byte being returned.
   logic armed = 1'b0;                 // High inside a byte.
   int idx = 0;                        // Bits already presented.
   int edges = 0;                      // Clock edges seen in this byte.
   initial o_miso = 1'b1;
   initial o_got = 8'h00;
   // Presents the next bit; past the last one the line shows the inverse, so stale data fails.
   task automatic present();
      if (idx < 8) begin
         o_miso = i_lsb_first ? tx_byte[idx] : tx_byte[7 - idx];
      end else begin
         o_miso = ~o_miso;
      end
      idx = idx + 1;
   endtask : present
   // There is no select input; the bench arms each byte instead.
   always @(posedge i_load) begin
      tx_byte = i_load_data;
      idx = 0;
      edges = 0;
      armed = 1'b1;
      if (!i_cpha) present();
   end
   // Samples on one edge and shifts on the other, as the phase selects.
   always @(i_sck) begin
      if (armed) begin
         edges = edges + 1;
         if (i_sck ^ i_cpol ^ i_cpha) begin
            o_got = i_lsb_first ? {i_mosi, o_got[7:1]} : {o_got[6:0], i_mosi};
         end else begin
            present();
         end
         if (edges == 16) begin
            armed = 1'b0;
            o_miso = ~o_miso;
         end
      end
   end
endmodule : usmr_spi_slave
`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking bench for the SPI-master and RS-485 serial port block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // One row: configuration, byte sent and byte the slave returns.
   typedef struct packed {
      logic mode;
      logic cpha;
      logic cpol;
      logic lsb;
      logic two;
      logic [1:0] ldm;
      logic [15:0] div;
      logic [7:0] d;
      logic [7:0] s;
   } usmr_row_t;
   logic i_ref_clk = 1'b0;
   logic i_rst_n = 1'b0;
   usmr_pkg::usmr_cfg_t cfg = '0;
   logic [7:0] tx_data = 8'h00;
   logic [7:0] load_data = 8'h00;
   logic tx_valid = 1'b0;
   logic load = 1'b0;
   logic tx_ready, rx_valid, busy, miso, started, te_q, sck_q, busy_q;
   logic [7:0] rx_data, got;
   usmr_pkg::usmr_pins_t pins;
   int mismatches = 0;
   int total_checks = 0;
   int edges, rxv, takes, falls, guard, gap, oe_bad, te_hi; // Per-test tallies.
   usmr_row_t rows [8] = '{
      {1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 2'h0, 16'h0003, 8'ha5, 8'h3c},
      {1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 2'h1, 16'h0003, 8'h96, 8'he1},
      {1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 2'h0, 16'h0003, 8'h01, 8'h80},
      {1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 2'h0, 16'h0004, 8'hff, 8'h00},
      {1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 2'h0, 16'h0001, 8'h55, 8'h00},
      {1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 2'h1, 16'h0003, 8'hc3, 8'h00},
      {1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 2'h2, 16'h0001, 8'h0f, 8'h00},
      {1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 2'h3, 16'h0002, 8'h5a, 8'h00}};
   always #5 i_ref_clk = ~i_ref_clk;
   // Outside SPI mode the receive line idles high.
   logic miso_or_idle;
   assign miso_or_idle = cfg.mode ? miso : 1'b1;
   usmr_core i_dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_cfg(cfg),
      .i_tx_data(tx_data), .i_tx_valid(tx_valid), .o_tx_ready(tx_ready),
      .i_rxd(miso_or_idle), .o_rx_data(rx_data), .o_rx_valid(rx_valid),
      .o_busy(busy), .o_pins(pins));
   usmr_spi_slave i_slave (.i_sck(pins.transfer_clock_line), .i_mosi(pins.txd),
      .i_cpol(cfg.clock_polarity), .i_cpha(cfg.clock_phase_select),
      .i_lsb_first(cfg.bit_order_select), .i_load(load), .i_load_data(load_data),
      .o_miso(miso), .o_got(got));
   // Watches the pins at the falling edge, where everything has settled.
   always @(negedge i_ref_clk) begin
      if (pins.transfer_clock_line !== sck_q) edges++;
      if (rx_valid === 1'b1) rxv++;
      if (tx_valid && tx_ready === 1'b1) takes++;
      if (te_q === 1'b1 && pins.transmit_enable_out === 1'b0) falls++;
      if (pins.transmit_enable_out === 1'b1) te_hi = 1;
      if (pins.transmit_enable_out === 1'b1 && !started && pins.txd === 1'b1) guard++;
      if (pins.txd === 1'b0) started = 1'b1;
      // The enable follows the registered pins, so it trails busy by one clock.
      if (busy_q === 1'b1 && pins.transmit_enable_out !== 1'b1 && !cfg.mode
          && cfg.line_driver_mode inside {2'h1, 2'h2}) gap++;
      if (pins.txd === 1'b0 && pins.txd_oe !== 1'b1) oe_bad++;
      te_q = pins.transmit_enable_out;
      sck_q = pins.transfer_clock_line;
      busy_q = busy;
   end
   task automatic clr();
      {edges, rxv, takes, falls, guard, gap, oe_bad, te_hi} = '0;
      started = 1'b0;
   endtask : clr
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] act);
      total_checks++;
      if (act !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", name, exp, act);
      end
   endtask : chk
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_sim
   // Offers a byte and holds it until taken; valid stays up for back-to-back use.
   task automatic take(input logic [7:0] d);
      int n;
      @(posedge i_ref_clk);
      tx_valid <= 1'b1;
      tx_data <= d;
      n = 0;
      do begin
         @(negedge i_ref_clk);
         n++;
      end while (tx_ready !== 1'b1 && n < 3000);
      if (n >= 3000) begin
         mismatches++;
         end_sim();
      end
   endtask : take
   // Lets the last offer be taken, then waits for the transmitter to go idle.
   task automatic finish_frame();
      int n;
      @(posedge i_ref_clk);
      tx_valid <= 1'b0;
      n = 0;
      do begin
         @(negedge i_ref_clk);
         n++;
      end while (busy !== 1'b0 && n < 3000);
      if (n >= 3000) begin
         mismatches++;
         end_sim();
      end
      repeat (2) @(negedge i_ref_clk);
   endtask : finish_frame
   // Sets a configuration, lets the clock pin settle, then arms the slave.
   task automatic setup(input usmr_row_t r);
      @(posedge i_ref_clk);
      cfg <= {r.mode, r.cpha, r.cpol, r.lsb, r.two, r.ldm, r.div};
      load_data <= r.s;
      repeat (3) @(posedge i_ref_clk);
      load <= 1'b1;
      @(posedge i_ref_clk);
      load <= 1'b0;
      clr();
   endtask : setup
   initial begin
      logic rs;
      repeat (2) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      @(negedge i_ref_clk);
      chk("txd", 1'b1, pins.txd);
      chk("te", 1'b0, pins.transmit_enable_out);
      chk("busy", 1'b0, busy);
      chk("sck", 1'b0, pins.transfer_clock_line);
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         setup(rows[i]);
         take(rows[i].d);
         finish_frame();
         rs = (rows[i].ldm == 2'h1) || (rows[i].ldm == 2'h2);
         if (rows[i].mode) begin
            chk("rx_data", rows[i].s, rx_data);
            chk("slave_got", rows[i].d, got);
            chk("clock_edges", 16'h0010, edges);
            chk("rx_pulses", 16'h0001, rxv);
            chk("te_in_spi", 16'h0000, te_hi);
         end else begin
            chk("te_used", rs, te_hi);
            chk("te_falls", rs, falls);
            chk("te_gaps", 16'h0000, gap);
            if (rs) chk("guard", rows[i].div + 16'h0001, guard);
            chk("oe_idle", rows[i].ldm != 2'h2, pins.txd_oe);
            chk("oe_frame", 16'h0000, oe_bad);
         end
         chk("takes", 16'h0001, takes);
         $display("test %0d done", i);
      end
      // Back-to-back bytes; the second is offered, and refused, all through the first.
      setup(rows[5]);
      take(8'h11);
      take(8'h22);
      finish_frame();
      chk("b2b_takes", 16'h0002, takes);
      chk("b2b_falls", 16'h0001, falls);
      chk("b2b_gaps", 16'h0000, gap);
      $display("test back_to_back done");
      // Reset in mid-frame must drop the enable at once.
      setup(rows[6]);
      take(8'h3c);
      @(posedge i_ref_clk);
      tx_valid <= 1'b0;
      repeat (5) @(posedge i_ref_clk);
      i_rst_n <= 1'b0;
      repeat (2) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      @(negedge i_ref_clk);
      chk("rst_busy", 1'b0, busy);
      chk("rst_te", 1'b0, pins.transmit_enable_out);
      $display("test mid_reset done");
      end_sim();
   end
endmodule : tb_top
`default_nettype wire
